// ===== core/pll_cfg_pkg.sv
package pll_cfg_pkg;

	// Register map
	localparam int NUM_REGS = 9;
	localparam logic [12:0] ADDR_CFG = 13'h0000;
	localparam logic [12:0] ADDR_PRESCALE = 13'h0004;
	localparam logic [12:0] ADDR_FB_HIGH = 13'h0005;
	localparam logic [12:0] ADDR_FB_LOW = 13'h0006;
	localparam logic [12:0] ADDR_REF_LOSS = 13'h0007;
	localparam logic [12:0] ADDR_PUMP = 13'h0008;

	// Field positions
	localparam int CFG_LONG_BIT = 4;
	localparam int CFG_SOFT_BIT = 5;
	localparam int CFG_LSB_BIT = 6;
	localparam int CFG_3WIRE_BIT = 7;
	localparam int REF_EN_BIT = 2;
	localparam int LOCK_DLY_LSB = 5;
	localparam int PUMP_LSB = 0;

	// Writable bits; the rest read as zero
	localparam logic [7:0] MASK_CFG = 8'hF0;
	localparam logic [7:0] MASK_PRESCALE = 8'h3F;
	localparam logic [7:0] MASK_FB_HIGH = 8'h1F;
	localparam logic [7:0] MASK_FB_LOW = 8'hFF;
	localparam logic [7:0] MASK_REF_LOSS = 8'h64;
	localparam logic [7:0] MASK_PUMP = 8'h7F;

	// Values after reset
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_PRESCALE = 8'h00;
	localparam logic [7:0] RST_FB_HIGH = 8'h00;
	localparam logic [7:0] RST_FB_LOW = 8'h00;
	localparam logic [7:0] RST_REF_LOSS = 8'h00;
	localparam logic [7:0] RST_PUMP = 8'h00;

	// Serial framing lengths
	localparam logic [4:0] LONG_INSTR_BITS = 5'h10;
	localparam logic [4:0] SHORT_INSTR_BITS = 5'h08;
	localparam logic [4:0] BYTE_BITS = 5'h08;

	// Lock cycles before monitoring starts
	localparam logic [4:0] LOCK_DLY_3 = 5'h03;
	localparam logic [4:0] LOCK_DLY_6 = 5'h06;
	localparam logic [4:0] LOCK_DLY_12 = 5'h0C;
	localparam logic [4:0] LOCK_DLY_24 = 5'h18;

	typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} phase_t;

	typedef struct packed {
		logic three_wire;
		logic lsb_first;
		logic soft_reset;
		logic long_instr;
	} port_cfg_t;

	typedef struct packed {
		logic [5:0] prescaler;
		logic [12:0] feedback;
		logic ref_loss_en;
		logic [1:0] lock_delay;
		logic [1:0] pump_mode;
	} pll_settings_t;

	function automatic logic [7:0] reg_mask(input int idx);
		unique case (idx)
			0: reg_mask = MASK_CFG;
			4: reg_mask = MASK_PRESCALE;
			5: reg_mask = MASK_FB_HIGH;
			6: reg_mask = MASK_FB_LOW;
			7: reg_mask = MASK_REF_LOSS;
			8: reg_mask = MASK_PUMP;
			default: reg_mask = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] reg_reset(input int idx);
		unique case (idx)
			0: reg_reset = RST_CFG;
			4: reg_reset = RST_PRESCALE;
			5: reg_reset = RST_FB_HIGH;
			6: reg_reset = RST_FB_LOW;
			7: reg_reset = RST_REF_LOSS;
			8: reg_reset = RST_PUMP;
			default: reg_reset = 8'h00;
		endcase
	endfunction

	function automatic logic [4:0] lock_delay_count(input logic [1:0] code);
		unique case (code)
			2'h0: lock_delay_count = LOCK_DLY_3;
			2'h1: lock_delay_count = LOCK_DLY_6;
			2'h2: lock_delay_count = LOCK_DLY_12;
			2'h3: lock_delay_count = LOCK_DLY_24;
		endcase
	endfunction

endpackage

// ===== core/pll_serial_port_config_regs.sv
`timescale 1ns/1ps
module pll_serial_port_config_regs
	import pll_cfg_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n_out,
	output logic serial_out_pin_out,
	output logic serial_out_pin_oe_n_out,
	input wire logic phase_detector_tick_in,
	input wire logic lock_detect_in,
	output logic reference_loss_monitor_out,
	output port_cfg_t port_cfg_out,
	output pll_settings_t settings_out
);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	// Pin synchronisers; stage 0 feeds stage 1 only
	logic [2:0] sclk_sync_ff, nxt_sclk_sync;
	logic [1:0] cs_sync_ff, nxt_cs_sync;
	logic [1:0] sdio_sync_ff, nxt_sdio_sync;
	logic sclk_rise, sclk_fall, cs_high, din;

	always_comb begin
		nxt_sclk_sync = {sclk_sync_ff[1:0], sclk_in};
		nxt_cs_sync = {cs_sync_ff[0], cs_n_in};
		nxt_sdio_sync = {sdio_sync_ff[0], sdio_in};
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			sclk_sync_ff <= 3'h0;
			cs_sync_ff <= 2'h3;
			sdio_sync_ff <= 2'h0;
		end else begin
			sclk_sync_ff <= nxt_sclk_sync;
			cs_sync_ff <= nxt_cs_sync;
			sdio_sync_ff <= nxt_sdio_sync;
		end
	end

	// Edges seen on the synchronised copies only
	assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
	assign cs_high = cs_sync_ff[1];
	assign din = sdio_sync_ff[1];

	// Serial engine and register file state
	phase_t state_ff, nxt_state;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [15:0] instr_ff, nxt_instr;
	logic rw_read_ff, nxt_rw_read;
	logic [12:0] addr_ff, nxt_addr;
	logic [7:0] rx_ff, nxt_rx;
	logic [7:0] tx_ff, nxt_tx;
	logic out_bit_ff, nxt_out_bit;
	logic sdio_oe_n_ff, nxt_sdio_oe_n;
	logic out_pin_oe_n_ff, nxt_out_pin_oe_n;
	logic [7:0] regs_ff [NUM_REGS];
	logic [7:0] nxt_regs [NUM_REGS];
	logic msb_first, long_instr, three_wire, soft_on, instr_done;
	logic byte_done, rd_active, wr_fire;
	logic [4:0] ilen;
	logic [3:0] ibit;
	logic [2:0] dbit;
	logic [12:0] wr_addr;
	logic [7:0] wr_data;

	// Unmapped and reserved addresses read as zero
	function automatic logic [7:0] read_reg(input logic [12:0] a);
		read_reg = (a < 13'(NUM_REGS)) ? regs_ff[a[3:0]] : 8'h00;
	endfunction

	// Port settings act straight from the stored bits
	assign msb_first = ~regs_ff[0][CFG_LSB_BIT];
	assign long_instr = regs_ff[0][CFG_LONG_BIT];
	assign three_wire = regs_ff[0][CFG_3WIRE_BIT];
	assign soft_on = regs_ff[0][CFG_SOFT_BIT];
	assign ilen = long_instr ? LONG_INSTR_BITS : SHORT_INSTR_BITS;
	assign ibit = msb_first ? 4'(ilen - 5'h01 - cnt_ff) : cnt_ff[3:0];
	assign dbit = msb_first ? 3'(5'h07 - cnt_ff) : cnt_ff[2:0];

	// Frame decode, shifting, streaming address and writes
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_instr = instr_ff;
		nxt_rw_read = rw_read_ff;
		nxt_addr = addr_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_out_bit = out_bit_ff;
		instr_done = 1'b0;
		byte_done = 1'b0;
		wr_fire = 1'b0;
		wr_addr = addr_ff;
		wr_data = 8'h00;
		if (cs_high) begin
			nxt_state = ST_IDLE;
			nxt_cnt = 5'h00;
			nxt_instr = 16'h0000;
			nxt_rw_read = 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE, ST_INSTR: begin
					nxt_state = ST_INSTR;
					if (sclk_rise) begin
						nxt_instr[ibit] = din;
						if (cnt_ff == ilen - 5'h01) begin
							instr_done = 1'b1;
							nxt_cnt = 5'h00;
							nxt_state = ST_DATA;
							if (long_instr) begin
								nxt_rw_read = nxt_instr[15];
								nxt_addr = nxt_instr[12:0];
							end else begin
								nxt_rw_read = nxt_instr[7];
								nxt_addr = {8'h00, nxt_instr[4:0]};
							end
							nxt_tx = read_reg(nxt_addr);
						end else begin
							nxt_cnt = cnt_ff + 5'h01;
						end
					end
				end
				ST_DATA: begin
					if (sclk_rise) begin
						nxt_rx[dbit] = din;
						if (cnt_ff == BYTE_BITS - 5'h01) begin
							byte_done = 1'b1;
							wr_fire = ~rw_read_ff;
							wr_data = nxt_rx;
							nxt_cnt = 5'h00;
							// Address walks down MSB first, up LSB first
							nxt_addr = msb_first ? addr_ff - 13'h0001 :
								addr_ff + 13'h0001;
							nxt_tx = read_reg(nxt_addr);
						end else begin
							nxt_cnt = cnt_ff + 5'h01;
						end
					end
					// Read data changes on the falling clock edge
					if (sclk_fall && rw_read_ff) begin
						nxt_out_bit = tx_ff[dbit];
					end
				end
			endcase
		end
		// Only one pin drives, chosen by the three-wire bit
		rd_active = (nxt_state == ST_DATA) && nxt_rw_read;
		nxt_sdio_oe_n = ~(rd_active & three_wire);
		nxt_out_pin_oe_n = ~(rd_active & ~three_wire);
		// Register 00 lands next cycle; no update strobe waits for it
		for (int i = 0; i < NUM_REGS; i++) begin
			nxt_regs[i] = regs_ff[i];
			if (wr_fire && wr_addr == 13'(i)) begin
				nxt_regs[i] = wr_data & reg_mask(i);
			end
			// Held at defaults until software writes the bit low again
			if (i != 0 && nxt_regs[0][CFG_SOFT_BIT]) begin
				nxt_regs[i] = reg_reset(i);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 5'h00;
			instr_ff <= 16'h0000;
			rw_read_ff <= 1'b0;
			addr_ff <= 13'h0000;
			rx_ff <= 8'h00;
			tx_ff <= 8'h00;
			out_bit_ff <= 1'b0;
			sdio_oe_n_ff <= 1'b1;
			out_pin_oe_n_ff <= 1'b1;
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_ff[i] <= reg_reset(i);
			end
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			instr_ff <= nxt_instr;
			rw_read_ff <= nxt_rw_read;
			addr_ff <= nxt_addr;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			out_bit_ff <= nxt_out_bit;
			sdio_oe_n_ff <= nxt_sdio_oe_n;
			out_pin_oe_n_ff <= nxt_out_pin_oe_n;
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_ff[i] <= nxt_regs[i];
			end
		end
	end

	// Initial-lock qualifier for the reference loss monitor
	logic [4:0] lock_cnt_ff, nxt_lock_cnt;
	logic mon_ff, nxt_mon;
	logic [4:0] lock_thr;
	logic ref_en;

	assign ref_en = regs_ff[ADDR_REF_LOSS[3:0]][REF_EN_BIT];
	assign lock_thr = lock_delay_count(
		regs_ff[ADDR_REF_LOSS[3:0]][LOCK_DLY_LSB +: 2]);

	// Lock must hold across consecutive ticks; a drop restarts the count
	always_comb begin
		nxt_lock_cnt = lock_cnt_ff;
		nxt_mon = mon_ff;
		if (!ref_en || soft_on) begin
			nxt_lock_cnt = 5'h00;
			nxt_mon = 1'b0;
		end else if (!mon_ff) begin
			if (!lock_detect_in) begin
				nxt_lock_cnt = 5'h00;
			end else if (phase_detector_tick_in) begin
				if (lock_cnt_ff == lock_thr - 5'h01) begin
					nxt_mon = 1'b1;
					nxt_lock_cnt = 5'h00;
				end else begin
					nxt_lock_cnt = lock_cnt_ff + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			lock_cnt_ff <= 5'h00;
			mon_ff <= 1'b0;
		end else begin
			lock_cnt_ff <= nxt_lock_cnt;
			mon_ff <= nxt_mon;
		end
	end

	// Outputs, all taken from flip-flops
	assign sdio_out = out_bit_ff;
	assign serial_out_pin_out = out_bit_ff;
	assign sdio_oe_n_out = sdio_oe_n_ff;
	assign serial_out_pin_oe_n_out = out_pin_oe_n_ff;
	assign reference_loss_monitor_out = mon_ff;
	assign port_cfg_out = '{three_wire: three_wire,
		lsb_first: regs_ff[0][CFG_LSB_BIT], soft_reset: soft_on,
		long_instr: long_instr};
	assign settings_out.prescaler = regs_ff[ADDR_PRESCALE[3:0]][5:0];
	assign settings_out.feedback = {regs_ff[ADDR_FB_HIGH[3:0]][4:0],
		regs_ff[ADDR_FB_LOW[3:0]]};
	assign settings_out.ref_loss_en = ref_en;
	assign settings_out.lock_delay =
		regs_ff[ADDR_REF_LOSS[3:0]][LOCK_DLY_LSB +: 2];
	assign settings_out.pump_mode = regs_ff[ADDR_PUMP[3:0]][PUMP_LSB +: 2];

	// Checks
	sequence s_byte_end;
		state_ff == ST_DATA && sclk_rise && cnt_ff == 5'h07 && !cs_high;
	endsequence

	sequence s_cfg_write;
		wr_fire && wr_addr == ADDR_CFG;
	endsequence

	a_cfg_write_now: assert property (
		s_cfg_write |=> regs_ff[0] == ($past(wr_data) & MASK_CFG))
		else $error("config write did not land next cycle");
	a_instr_length: assert property (
		instr_done |-> cnt_ff == (long_instr ? 5'h0F : 5'h07))
		else $error("instruction phase length wrong");
	a_soft_defaults: assert property (
		soft_on |-> regs_ff[ADDR_PUMP[3:0]] == RST_PUMP &&
		regs_ff[ADDR_FB_LOW[3:0]] == RST_FB_LOW)
		else $error("registers not at defaults in soft reset");
	a_soft_sticky: assert property (
		soft_on && !wr_fire |=> soft_on)
		else $error("soft reset cleared itself");
	a_addr_down_msb: assert property (
		s_byte_end ##0 msb_first |=> addr_ff == $past(addr_ff) - 13'h0001)
		else $error("address did not step down");
	a_addr_up_lsb: assert property (
		s_byte_end ##0 !msb_first |=> addr_ff == $past(addr_ff) + 13'h0001)
		else $error("address did not step up");
	a_out_pin_release: assert property (
		three_wire |=> serial_out_pin_oe_n_out)
		else $error("serial output pin driven in three-wire mode");
	a_monitor_delay: assert property (
		$rose(mon_ff) |-> $past(lock_thr) == $past(lock_cnt_ff) + 5'h01 &&
		$past(lock_detect_in) && $past(phase_detector_tick_in))
		else $error("monitor enabled after wrong lock count");
	a_feedback_split: assert property (
		wr_fire && wr_addr == ADDR_FB_HIGH && !soft_on |=>
		{3'h0, settings_out.feedback[12:8]} ==
		($past(wr_data) & MASK_FB_HIGH))
		else $error("feedback high bits misplaced");

endmodule

// ===== verification/serial_host.sv
`timescale 1ns/1ps
module serial_host (
	input wire logic clk_in,
	input wire logic sdio_wire_in,
	input wire logic serial_out_pin_in,
	input wire logic sdio_oe_n_in,
	input wire logic serial_out_pin_oe_n_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic sdio_out
);
	logic drive = 0, val = 0, idle_ff = 0;
	logic lsb_first = 0, long_instr = 0, three_wire = 0;
	logic [1:0] oe_seen = 2'h3;
	int extra = 0;
	initial begin
		sclk_out = 0;
		cs_n_out = 1;
	end
	// Released line toggles so stale data never looks valid
	always @(negedge clk_in) begin
		idle_ff <= ~idle_ff;
	end
	assign sdio_out = drive ? val : idle_ff;
	// One sclk period, five clocks low then five high
	task automatic clk_bit(input logic d, input logic en, output logic q);
		drive = en;
		val = d;
		sclk_out = 0;
		repeat (5) @(negedge clk_in);
		q = three_wire ? sdio_wire_in : serial_out_pin_in;
		oe_seen = {sdio_oe_n_in, serial_out_pin_oe_n_in};
		sclk_out = 1;
		repeat (5) @(negedge clk_in);
	endtask
	// Whole frame: instruction then extra+1 data bytes
	task automatic xfer(input logic rd, input logic [12:0] a,
		input logic [7:0] w, output logic [7:0] r);
		logic [15:0] ins;
		int n;
		logic b;
		n = long_instr ? 16 : 8;
		ins = long_instr ? {rd, 2'h0, a} : {8'h00, rd, 2'h0, a[4:0]};
		cs_n_out = 0;
		repeat (5) @(negedge clk_in);
		for (int i = 0; i < n; i++) begin
			clk_bit(ins[lsb_first ? i : n - 1 - i], 1'b1, b);
		end
		// Extra bytes stream to the next address with the same data
		for (int k = 0; k <= extra; k++) begin
			for (int i = 0; i < 8; i++) begin
				clk_bit(w[lsb_first ? i : 7 - i], !rd, b);
				r[lsb_first ? i : 7 - i] = b;
			end
		end
		sclk_out = 0;
		drive = 0;
		repeat (5) @(negedge clk_in);
		cs_n_out = 1;
		repeat (6) @(negedge clk_in);
	endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
	import pll_cfg_pkg::*;
	typedef struct packed {
		logic [12:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} row_t;
	logic clk_in = 0, nrst_in = 0, tick = 0, lock = 0;
	logic sclk, cs_n, h_sdio, d_sdio, sd_oe_n, so_pin, so_oe_n, mon, wire_v;
	logic so_v;
	port_cfg_t cfg;
	pll_settings_t set;
	int mismatches = 0, comparisons = 0, n;
	logic [7:0] rd;
	row_t rows [7] = '{{13'h0004, 8'hFF, 8'h3F}, {13'h0005, 8'hFF, 8'h1F},
		{13'h0006, 8'hA5, 8'hA5}, {13'h0007, 8'hFF, 8'h64},
		{13'h0008, 8'hFF, 8'h7F}, {13'h0002, 8'hFF, 8'h00},
		{13'h000B, 8'hFF, 8'h00}};
	logic [7:0] dly [4] = '{8'h03, 8'h06, 8'h0C, 8'h18};
	always #4 clk_in = ~clk_in;
	// Bidirectional data line as both parties see it
	assign wire_v = !sd_oe_n ? d_sdio : h_sdio;
	// Released output pin shows the inverse, so a late enable is caught
	assign so_v = !so_oe_n ? so_pin : ~so_pin;
	pll_serial_port_config_regs u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .sdio_in(wire_v), .sdio_out(d_sdio),
		.sdio_oe_n_out(sd_oe_n), .serial_out_pin_out(so_pin),
		.serial_out_pin_oe_n_out(so_oe_n), .phase_detector_tick_in(tick),
		.lock_detect_in(lock), .reference_loss_monitor_out(mon),
		.port_cfg_out(cfg), .settings_out(set));
	serial_host u_host (.clk_in(clk_in), .sdio_wire_in(wire_v),
		.serial_out_pin_in(so_v), .sdio_oe_n_in(sd_oe_n),
		.serial_out_pin_oe_n_in(so_oe_n), .sclk_out(sclk), .cs_n_out(cs_n),
		.sdio_out(h_sdio));
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_set(input pll_settings_t g, input pll_settings_t e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL at %0t: settings %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		u_host.xfer(1'b0, a, d, rd);
	endtask
	task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
		u_host.xfer(1'b1, a, 8'h00, rd);
		chk_byte(rd, e);
	endtask
	// One detector tick, spaced so the monitor can settle
	task automatic pulse;
		tick = 1;
		@(negedge clk_in);
		tick = 0;
		repeat (3) @(negedge clk_in);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, well past the expected run time
	initial begin
		#400000;
		mismatches++;
		$display("FAIL at %0t: watchdog expired", $time);
		print_verdict();
	end
	initial begin
		repeat (6) @(negedge clk_in);
		nrst_in = 1;
		repeat (5) @(negedge clk_in);
		chk_set(set, '0);
		chk_byte({2'h0, cfg, sd_oe_n, so_oe_n}, 8'h03);
		$display("test reset done");
		// Masks, reserved and unmapped places, four-wire read pin
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd_chk(rows[i].a, rows[i].e);
			chk_byte({6'h00, u_host.oe_seen}, 8'h02);
		end
		chk_set(set, {6'h3F, 13'h1FA5, 1'b1, 2'h3, 2'h3});
		$display("test rows done");
		// Lock delay codes; a lock drop restarts the count
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_REF_LOSS, 8'h00);
			wr(ADDR_REF_LOSS, {1'b0, c[1:0], 5'h04});
			lock = 1;
			if (c == 0) begin
				pulse();
				pulse();
				lock = 0;
				pulse();
				lock = 1;
			end
			n = 0;
			while (mon !== 1'b1 && n < 30) begin
				pulse();
				n++;
			end
			chk_byte(n[7:0], dly[c]);
			lock = 0;
			pulse();
		end
		$display("test lock done");
		wr(ADDR_CFG, 8'h10);
		chk_byte({4'h0, cfg}, 8'h01);
		u_host.long_instr = 1;
		u_host.extra = 1;
		wr(ADDR_FB_LOW, 8'h3C);
		u_host.extra = 0;
		rd_chk(ADDR_FB_LOW, 8'h3C);
		rd_chk(ADDR_FB_HIGH, 8'h1C);
		wr(ADDR_CFG, 8'h50);
		u_host.lsb_first = 1;
		wr(ADDR_FB_HIGH, 8'h13);
		rd_chk(ADDR_FB_HIGH, 8'h13);
		u_host.extra = 1;
		wr(ADDR_PRESCALE, 8'h2A);
		u_host.extra = 0;
		rd_chk(ADDR_FB_HIGH, 8'h0A);
		wr(ADDR_CFG, 8'hDF);
		u_host.three_wire = 1;
		rd_chk(ADDR_CFG, 8'hD0);
		chk_byte({6'h00, u_host.oe_seen}, 8'h01);
		$display("test port modes done");
		wr(ADDR_CFG, 8'hF0);
		chk_set(set, '0);
		wr(ADDR_PRESCALE, 8'h15);
		chk_set(set, '0);
		wr(ADDR_CFG, 8'hD0);
		wr(ADDR_PRESCALE, 8'h15);
		rd_chk(ADDR_PRESCALE, 8'h15);
		$display("test soft reset done");
		nrst_in = 0;
		repeat (2) @(negedge clk_in);
		chk_set(set, '0);
		chk_byte({2'h0, cfg, sd_oe_n, so_oe_n}, 8'h03);
		nrst_in = 1;
		u_host.long_instr = 0;
		u_host.lsb_first = 0;
		u_host.three_wire = 0;
		repeat (5) @(negedge clk_in);
		rd_chk(ADDR_PRESCALE, 8'h00);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule
